// ### src/pcg_top.sv
/*
 * Clock generator control: registers, write protection, lock-change flag,
 * base clock selection and glitch-free switchover. Assumes the oscillator
 * and VCO clocks and the lock/track status arrive as levels synchronous to
 * i_ref_clk, and a register port with read data one cycle after the strobe.
 */
`timescale 1ns/1ps
// Contract
// RL1: Output from oscillator divided by two, or VCO divided by three.
// RL2: Output has even duty and is half the oscillator rate or a third of the VCO rate.
// RL3: Output held static while switching, three edges of each clock.
// RL4: Source select cannot be set while the PLL is off.
// RL5: PLL cannot be turned off while source select is set.
// RL6: Software turns PLL on, then sets source select, in two writes.
// RL7: Interrupt enable ignores writes and reads zero in manual mode.
// RL8: Lock change sets flag; irq while flag and enable both set.
// RL9: Flag reads zero in manual mode; reset clears it.
// RL10: Any read of control register clears the flag; a lock change in the same cycle sets it instead.
// RL11: Reset turns PLL on and selects the oscillator path.
// RL12: Prescale field locked while PLL on; resets to zero.
// RL13: VCO power-of-two range locked while PLL on; resets to zero.
// RL14: Software never writes range code three.
// RL15: Auto bandwidth bit resets to zero; manual needs acquire cleared first.
// RL16: Lock indicator follows lock in auto mode, zero in manual.
// RL17: Software always writes zero to the lock bit.
// RL18: Acquire bit read-only status in auto, writable control in manual.
// RL19: Manual acquire value kept while auto and restored afterwards.
// RL20: Twelve-bit multiplier, zero acts as one, resets to 64.
// RL21: Multiplier registers locked while PLL on.
// RL22: Linear range register locked while PLL on, resets to 64.
// RL23: Zero linear range disables PLL and forces oscillator source.
// RL24: Undefined bits read zero; registers are eight bits wide.
module pcg_top (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_osc_clock,
    input wire logic i_vco_clock,
    input wire logic i_vco_locked,
    input wire logic i_vco_tracking,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_base_clock_out,
    output logic o_pll_irq_out,
    output logic o_pll_active,
    output logic [11:0] o_mul_eff,
    output pcg_pkg::pcg_cfg_t o_cfg
);
    typedef enum logic [2:0] {
        SEL_OSC = 3'b001,
        SEL_WAIT = 3'b010,
        SEL_VCO = 3'b100
    } pcg_sel_t;

    logic ie_q;
    logic flag_q;
    logic on_q;
    logic bcs_q;
    logic [1:0] pre_q;
    logic [1:0] vpr_q;
    logic auto_q;
    logic acq_man_q;
    logic lock_q;
    logic [11:0] mul_q;
    logic [7:0] vrs_q;
    logic [7:0] rdata_q;
    logic out_q;
    pcg_sel_t sel_q;
    pcg_sel_t sel_d;

    wire wr_ctrl = i_wr && i_addr == pcg_pkg::OFF_CTRL;
    wire wr_bw = i_wr && i_addr == pcg_pkg::OFF_BW;
    wire wr_hi = i_wr && i_addr == pcg_pkg::OFF_MUL_HI;
    wire wr_lo = i_wr && i_addr == pcg_pkg::OFF_MUL_LO;
    wire wr_vrs = i_wr && i_addr == pcg_pkg::OFF_VRS;
    wire rd_ctrl = i_rd && i_addr == pcg_pkg::OFF_CTRL;
    wire vrs_zero = (vrs_q == 8'h00);
    wire pll_run = on_q && !vrs_zero; // [RL23]
    wire lock_now = auto_q && pll_run && i_vco_locked; // [RL16]
    wire acq_vis = auto_q ? (pll_run && i_vco_tracking) : acq_man_q; // [RL18]
    wire w_on = i_wdata[pcg_pkg::CTL_ON];
    wire w_bcs = i_wdata[pcg_pkg::CTL_BCS];
    // New select only when PLL already on and range nonzero
    wire bcs_next = w_bcs && on_q && !vrs_zero; // [RL4] [RL23]
    // Clearing PLL refused while source select is set, even by the write clearing it
    wire on_next = w_on || bcs_q; // [RL5]
    wire lock_chg = lock_now != lock_q; // [RL8]
    // Bandwidth mode as it stands after this edge
    wire auto_d = wr_bw ? i_wdata[pcg_pkg::BW_AUTO] : auto_q;

    // Control register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ie_q <= 1'b0; // [RL7]
            on_q <= 1'b1; // [RL11]
            bcs_q <= 1'b0; // [RL11]
            pre_q <= pcg_pkg::PRE_RST; // [RL12]
            vpr_q <= pcg_pkg::VPR_RST; // [RL13]
        end else if (i_clk_en) begin
            if (!auto_d) begin
                ie_q <= 1'b0; // [RL7]
            end else if (wr_ctrl) begin
                ie_q <= i_wdata[pcg_pkg::CTL_IE];
            end
            if (vrs_zero) begin
                bcs_q <= 1'b0; // [RL23]
            end else if (wr_ctrl) begin
                bcs_q <= bcs_next;
            end
            if (wr_ctrl) begin
                on_q <= on_next;
                if (!on_q) begin
                    pre_q <= i_wdata[pcg_pkg::CTL_PRE +: 2]; // [RL12]
                    vpr_q <= i_wdata[pcg_pkg::CTL_VPR +: 2]; // [RL13]
                end
            end
        end
    end

    // Lock tracking and flag; a change wins over a read clear
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            lock_q <= 1'b0; // [RL16]
            flag_q <= 1'b0; // [RL9]
        end else if (i_clk_en) begin
            lock_q <= lock_now;
            if (!auto_d) begin
                flag_q <= 1'b0; // [RL9]
            end else if (lock_chg) begin
                flag_q <= 1'b1; // [RL8]
            end else if (rd_ctrl) begin
                flag_q <= 1'b0; // [RL10]
            end
        end
    end

    // Bandwidth register; manual acquire value survives auto mode
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            auto_q <= 1'b0; // [RL15]
            acq_man_q <= 1'b0; // [RL18]
        end else if (i_clk_en && wr_bw) begin
            auto_q <= i_wdata[pcg_pkg::BW_AUTO]; // [RL15]
            if (!auto_q) begin
                acq_man_q <= i_wdata[pcg_pkg::BW_ACQ]; // [RL19]
            end
        end
    end

    // Multiplier and range registers, locked while PLL on
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mul_q <= pcg_pkg::MUL_RST; // [RL20]
            vrs_q <= pcg_pkg::VRS_RST; // [RL22]
        end else if (i_clk_en && !on_q) begin
            if (wr_hi) begin
                mul_q[11:8] <= i_wdata[3:0]; // [RL21]
            end
            if (wr_lo) begin
                mul_q[7:0] <= i_wdata; // [RL21]
            end
            if (wr_vrs) begin
                vrs_q <= i_wdata; // [RL22]
            end
        end
    end

    // Read mux; undefined bits zero
    wire [7:0] rd_ctrl_v = {ie_q, flag_q && auto_q, on_q, bcs_q, 2'h0, 2'h0} | // [RL9]
        {4'h0, pre_q, vpr_q};
    wire [7:0] rd_bw_v = {auto_q, lock_q && auto_q, acq_vis, 5'h00}; // [RL16] [RL24]
    wire [7:0] rd_mux = (i_addr == pcg_pkg::OFF_CTRL) ? rd_ctrl_v :
        (i_addr == pcg_pkg::OFF_BW) ? rd_bw_v :
        (i_addr == pcg_pkg::OFF_MUL_HI) ? {4'h0, mul_q[11:8]} :
        (i_addr == pcg_pkg::OFF_MUL_LO) ? mul_q[7:0] :
        (i_addr == pcg_pkg::OFF_VRS) ? vrs_q : 8'h00; // [RL24]

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    // Source dividers and switchover counters
    logic osc_tick;
    logic vco_tick;
    logic osc_done;
    logic vco_done;
    wire arm = (sel_q != SEL_WAIT) && ((sel_q == SEL_VCO) != bcs_q);

    pcg_clk_div #(.DIV(pcg_pkg::OSC_DIV)) u_osc_div (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_src(i_osc_clock),
        .o_tick(osc_tick)
    );

    pcg_clk_div #(.DIV(pcg_pkg::VCO_DIV)) u_vco_div (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_src(i_vco_clock),
        .o_tick(vco_tick)
    );

    pcg_edge_count #(.COUNT(pcg_pkg::SWITCH_EDGES)) u_osc_cnt (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_src(i_osc_clock),
        .i_arm(arm),
        .o_done(osc_done)
    );

    pcg_edge_count #(.COUNT(pcg_pkg::SWITCH_EDGES)) u_vco_cnt (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_src(i_vco_clock),
        .i_arm(arm),
        .o_done(vco_done)
    );

    // Select sequencer
    always_comb begin
        sel_d = sel_q;
        unique case (sel_q)
            SEL_OSC: begin
                if (bcs_q) begin
                    sel_d = SEL_WAIT;
                end
            end
            SEL_VCO: begin
                if (!bcs_q) begin
                    sel_d = SEL_WAIT;
                end
            end
            SEL_WAIT: begin
                if (osc_done && vco_done) begin // [RL3]
                    sel_d = bcs_q ? SEL_VCO : SEL_OSC;
                end
            end
            default: begin
                sel_d = SEL_OSC;
            end
        endcase
    end

    wire out_tick = (sel_q == SEL_OSC) ? osc_tick :
        (sel_q == SEL_VCO) ? vco_tick : 1'b0; // [RL1] [RL3]

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sel_q <= SEL_OSC; // [RL11]
            out_q <= 1'b0;
        end else if (i_clk_en) begin
            sel_q <= sel_d;
            if (out_tick) begin
                out_q <= ~out_q; // [RL2]
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_base_clock_out = out_q;
    assign o_pll_irq_out = flag_q && ie_q; // [RL8]
    assign o_pll_active = pll_run;
    assign o_mul_eff = (mul_q == 12'h000) ? 12'h001 : mul_q; // [RL20]
    assign o_cfg = '{prescale_field: pre_q, vco_pow2_range_field: vpr_q,
        feedback_multiplier: mul_q, vco_linear_range: vrs_q,
        pll_enable: pll_run, acquire_track_bit: acq_vis, auto_mode: auto_q};
endmodule

// ### src/pcg_pkg.sv
/*
 * Package for the clock generator control block: register offsets, field
 * positions, reset values and structs. Assumes an 8-bit register port.
 */
package pcg_pkg;

    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_BW = 3'h1;
    localparam logic [2:0] OFF_MUL_HI = 3'h2;
    localparam logic [2:0] OFF_MUL_LO = 3'h3;
    localparam logic [2:0] OFF_VRS = 3'h4;

    // Control register bit positions
    localparam int CTL_IE = 7;
    localparam int CTL_FLAG = 6;
    localparam int CTL_ON = 5;
    localparam int CTL_BCS = 4;
    localparam int CTL_PRE = 2;
    localparam int CTL_VPR = 0;

    // Bandwidth register bit positions
    localparam int BW_AUTO = 7;
    localparam int BW_LOCK = 6;
    localparam int BW_ACQ = 5;

    localparam logic [11:0] MUL_RST = 12'h040;
    localparam logic [7:0] VRS_RST = 8'h40;
    localparam logic [1:0] PRE_RST = 2'h0;
    localparam logic [1:0] VPR_RST = 2'h0;

    // Clock dividers and switchover settle count
    localparam logic [1:0] OSC_DIV = 2'h2;
    localparam logic [1:0] VCO_DIV = 2'h3;
    localparam logic [1:0] SWITCH_EDGES = 2'h3;

    typedef struct packed {
        logic [1:0] prescale_field;
        logic [1:0] vco_pow2_range_field;
        logic [11:0] feedback_multiplier;
        logic [7:0] vco_linear_range;
        logic pll_enable;
        logic acquire_track_bit;
        logic auto_mode;
    } pcg_cfg_t;

endpackage

// ### src/pcg_edge_count.sv
/*
 * Counts rising edges of a sampled source clock once arming has cleared it; done after a
 * set count. Assumes the source level is synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
module pcg_edge_count #(
    parameter logic [1:0] COUNT = 2'h3
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_src,
    input wire logic i_arm,
    output logic o_done
);
    logic src_q;
    logic [1:0] cnt_q;
    wire rise = i_src & ~src_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            src_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (i_clk_en) begin
            src_q <= i_src;
            if (i_arm) begin
                cnt_q <= 2'h0;
            end else if (rise && cnt_q != COUNT) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    assign o_done = (cnt_q == COUNT);
endmodule

// ### src/pcg_clk_div.sv
/*
 * Divides a sampled source clock by a small count, counting both its edges.
 * Assumes the source level is synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
module pcg_clk_div #(
    parameter logic [1:0] DIV = 2'h2
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_src,
    output logic o_tick
);
    logic src_q;
    logic [1:0] cnt_q;
    wire flip = i_src ^ src_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            src_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (i_clk_en) begin
            src_q <= i_src;
            if (flip) begin
                cnt_q <= (cnt_q == DIV - 2'h1) ? 2'h0 : cnt_q + 2'h1;
            end
        end
    end

    // One pulse per DIV source edges
    assign o_tick = flip && (cnt_q == DIV - 2'h1);
endmodule

// ### bench/pcg_props.sv
/* Port checker for pcg_top.
   Bound from the testbench top file; one clock, sync reset. */
`timescale 1ns/1ps
module pcg_checker (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_rd,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire logic o_pll_irq_out,
    input wire logic o_pll_active,
    input wire logic [11:0] o_mul_eff,
    input wire pcg_pkg::pcg_cfg_t o_cfg
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) > 3'h4 |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_IRQ_AUTO: assert property (o_pll_irq_out |-> o_cfg.auto_mode)
        else $error("irq in manual mode");
    AST_CTRL_MANUAL: assert property ($past(i_rd) && $past(i_addr) == 3'h0 &&
        !$past(o_cfg.auto_mode) |-> o_rdata[7:6] == 2'h0)
        else $error("enable or flag visible in manual mode");
    AST_LOCK_MANUAL: assert property ($past(i_rd) && $past(i_addr) == 3'h1 &&
        !$past(o_cfg.auto_mode) |-> !o_rdata[6])
        else $error("lock visible in manual mode");
    AST_ACTIVE: assert property (o_pll_active == (o_cfg.pll_enable && o_cfg.vco_linear_range != 8'h00))
        else $error("pll active wrong");
    AST_MUL_EFF: assert property (o_mul_eff == ((o_cfg.feedback_multiplier == 12'h000) ?
        12'h001 : o_cfg.feedback_multiplier))
        else $error("effective multiplier wrong");
    AST_MUL_LOCK: assert property ($past(o_cfg.pll_enable) |-> $stable(o_cfg.feedback_multiplier))
        else $error("multiplier changed while on");
    AST_CFG_LOCK: assert property ($past(o_cfg.pll_enable) |-> $stable({o_cfg.prescale_field,
        o_cfg.vco_pow2_range_field, o_cfg.vco_linear_range}))
        else $error("range field changed while on");
    AST_RST: assert property ($fell(i_sys_rst) |-> o_cfg.pll_enable && o_rdata == 8'h00 &&
        o_cfg.vco_linear_range == 8'h40 && o_cfg.feedback_multiplier == 12'h040 &&
        o_cfg.prescale_field == 2'h0 && !o_cfg.auto_mode)
        else $error("reset values wrong");
    cover property (o_pll_irq_out);
    cover property ($rose(o_cfg.auto_mode));
    cover property (o_cfg.pll_enable && !o_pll_active);
endmodule

// ### bench/pcg_src_model.sv
/* Source model: oscillator and VCO clock levels, lock and track status.
   Assumes the reference clock of the block under test. */
`timescale 1ns/1ps
module pcg_src_model (
    input wire logic i_ref_clk,
    input wire logic i_lock_req,
    output logic o_osc_clock,
    output logic o_vco_clock,
    output logic o_vco_locked,
    output logic o_vco_tracking
);
    logic [1:0] osc_q = 2'h0;
    logic [1:0] vco_q = 2'h0;
    logic osc_lvl_q = 1'b0;
    logic vco_lvl_q = 1'b0;
    always @(posedge i_ref_clk) begin
        osc_q <= (osc_q == 2'h1) ? 2'h0 : osc_q + 2'h1;
        vco_q <= (vco_q == 2'h2) ? 2'h0 : vco_q + 2'h1;
        if (osc_q == 2'h1) begin
            osc_lvl_q <= ~osc_lvl_q;
        end
        if (vco_q == 2'h2) begin
            vco_lvl_q <= ~vco_lvl_q;
        end
    end
    assign o_osc_clock = osc_lvl_q;
    assign o_vco_clock = vco_lvl_q;
    assign o_vco_locked = i_lock_req;
    assign o_vco_tracking = i_lock_req;
endmodule

// ### bench/testbench.sv
/* Register-level testbench for pcg_top with a source model.
   Assumes a 50 MHz reference clock and the package register map. */
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst;
    logic wr_s;
    logic rd_s;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic lock_req;
    logic osc;
    logic vco;
    logic lck;
    logic trk;
    logic [7:0] rdata;
    logic base;
    logic irq;
    logic [11:0] mul_eff;
    pcg_pkg::pcg_cfg_t cfg;
    logic [7:0] rv;
    int n_errors = 0;
    int check_count = 0;
    pcg_top i_pcg_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
        .i_osc_clock(osc), .i_vco_clock(vco), .i_vco_locked(lck), .i_vco_tracking(trk),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .o_base_clock_out(base), .o_pll_irq_out(irq), .o_pll_active(),
        .o_mul_eff(mul_eff), .o_cfg(cfg));
    pcg_src_model i_pcg_src_model (.i_ref_clk(clk), .i_lock_req(lock_req),
        .o_osc_clock(osc), .o_vco_clock(vco), .o_vco_locked(lck), .o_vco_tracking(trk));
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic get(input logic [2:0] a);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        get(a);
        chk({4'h0, rv}, {4'h0, e});
    endtask
    task automatic meas(input int e);
        logic b;
        int n;
        b = base;
        for (n = 0; n < 60 && base === b; n++) step(1);
        b = base;
        for (n = 0; n < 60 && base === b; n++) step(1);
        chk(12'(n), 12'(e));
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        lock_req = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(3'h0, 8'h20);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h3, 8'h40);
        rd(3'h4, 8'h40);
        rd(3'h5, 8'h00);
        meas(4);
        $display("reset test done");
        wr(3'h3, 8'h12);
        wr(3'h4, 8'h55);
        wr(3'h0, 8'h2E);
        rd(3'h3, 8'h40);
        rd(3'h4, 8'h40);
        rd(3'h0, 8'h20);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h0F);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        step(1);
        chk(mul_eff, 12'h001);
        for (int k = 0; k < 4; k++) begin
            wr(3'h0, {4'h0, 2'(k), 2'(k % 3)});
            rd(3'h0, {4'h0, 2'(k), 2'(k % 3)});
        end
        $display("protection test done");
        wr(3'h0, 8'h1E);
        rd(3'h0, 8'h0E);
        wr(3'h0, 8'h2E);
        wr(3'h0, 8'h3E);
        rd(3'h0, 8'h3E);
        wr(3'h0, 8'h1E);
        rd(3'h0, 8'h3E);
        step(40);
        meas(9);
        wr(3'h0, 8'h0E);
        rd(3'h0, 8'h2E);
        step(40);
        meas(4);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h20);
        wr(3'h0, 8'h30);
        get(3'h0);
        chk({11'h000, rv[4]}, 12'h000);
        chk({11'h000, cfg.pll_enable}, 12'h000);
        $display("select test done");
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h40);
        wr(3'h0, 8'hA0);
        rd(3'h0, 8'h20);
        @(posedge clk);
        lock_req <= 1'b1;
        step(4);
        rd(3'h0, 8'h20);
        rd(3'h1, 8'h00);
        @(posedge clk);
        lock_req <= 1'b0;
        step(4);
        wr(3'h1, 8'hA0);
        rd(3'h1, 8'h80);
        wr(3'h0, 8'hA0);
        @(posedge clk);
        lock_req <= 1'b1;
        step(4);
        chk({11'h000, irq}, 12'h001);
        rd(3'h0, 8'hE0);
        rd(3'h1, 8'hE0);
        rd(3'h0, 8'hA0);
        chk({11'h000, irq}, 12'h000);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h20);
        rd(3'h0, 8'h20);
        $display("lock test done");
        stop_test();
    end
endmodule
bind pcg_top pcg_checker i_pcg_checker (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata), .o_pll_irq_out(o_pll_irq_out),
    .o_pll_active(o_pll_active), .o_mul_eff(o_mul_eff), .o_cfg(o_cfg));
